// [hw/irq_pulse_gen.sv]
`timescale 1ns/1ps
module irq_pulse_gen (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       osc_tick,
    input  wire logic       start,
    input  wire logic [1:0] src_sel,
    input  wire logic       count_is_one,
    output logic            active
);
    import rtc_ctl_pkg::*;

    typedef struct packed {
        logic [PW_W-1:0] cnt;
        logic            active;
    } pg_state_t;

    pg_state_t       q, d;
    logic [PW_W-1:0] width;

    always_comb begin
        d = q;
        case (src_sel)
            SRC_4096: width = count_is_one ? PW_4096_ONE : PW_4096;
            SRC_64:   width = count_is_one ? PW_64_ONE : PW_SLOW;
            default:  width = PW_SLOW;
        endcase
        if (start) begin
            d.cnt    = width;
            d.active = 1'b1;
        end else if (q.active && osc_tick) begin
            d.cnt    = q.cnt - 1'b1;
            d.active = (q.cnt != 1);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) q <= '0;
        else q <= d;
    end

    assign active = q.active;

    property p_width_load;
        @(posedge clk) disable iff (sys_rst)
            (start && src_sel == SRC_4096 && count_is_one) |=> q.cnt == 4 && active;
    endproperty
    a_width_load: assert property (p_width_load) else $error("bad narrow width");

    property p_width_slow;
        @(posedge clk) disable iff (sys_rst)
            (start && src_sel == SRC_1) |=> q.cnt == 512;
    endproperty
    a_width_slow: assert property (p_width_slow) else $error("bad slow width");
endmodule // irq_pulse_gen

// [hw/rtc_control_status_irq.sv]
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Bit 7 selects external clock test mode
// - Halt bit clears divider chain, stops clock
// - Square wave keeps running while halted
// - Bit 3 override enable, defaults to one
// - Level mode: interrupt follows countdown flag
// - Pulse mode: countdown interrupt is a pulse
// - Enabled alarm flag holds interrupt asserted
// - Alarm flag bit 3, write zero clears
// - Countdown flag bit 2, write zero clears
// - Alarm match sets alarm flag
// - Countdown end sets countdown flag
// - Flags hold until host overwrites them
// - Flag write is AND with written bit
// - Bit 1 alarm enable, bit 0 countdown
// - Interrupt is OR of enabled conditions
// - Pulse width depends on countdown value
// - Pulse widths per source clock table
// - Interrupt pin active low open drain
// - Registers at addresses 00h and 01h
// - Countdown end is count reaching zero
module rtc_control_status_irq (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic [3:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic       alarm_event,
    input  wire logic       countdown_zero,
    input  wire logic [1:0] countdown_src,
    input  wire logic [7:0] countdown_load,
    input  wire logic       external_test_clock,
    output logic            irq_n_out,
    output logic            irq_n_oe,
    output logic            square_wave_out,
    output logic            countdown_tick,
    output logic            second_tick,
    output logic            ext_clock_test_select,
    output logic            divider_halted,
    output logic            reset_override_enable
);
    import rtc_ctl_pkg::*;

    //////////////////////////////////////////////////////////////////////////
    // Submodules
    ctl_state_t q, d;
    logic       osc_tick;
    logic       pulse_active;
    logic       cd_end;
    logic       wr_one, wr_two;
    logic       cd_cond;
    logic       sq_raw, src_raw, sec_raw;
    logic       sq_q, src_q, sec_q;

    assign cd_end = countdown_zero;

    rtc_prescaler u_pre (
        .clk                 (clk),
        .sys_rst             (sys_rst),
        .halt                (q.halt),
        .test_mode           (q.test_sel),
        .external_test_clock (external_test_clock),
        .src_sel             (countdown_src),
        .square_out          (sq_raw),
        .osc_tick            (osc_tick),
        .src_tick            (src_raw),
        .sec_tick            (sec_raw)
    );

    irq_pulse_gen u_pulse (
        .clk          (clk),
        .sys_rst      (sys_rst),
        .osc_tick     (osc_tick),
        .start        (cd_end),
        .src_sel      (countdown_src),
        .count_is_one (countdown_load == 8'h01),
        .active       (pulse_active)
    );

    //////////////////////////////////////////////////////////////////////////
    // Register file and interrupt
    assign wr_one = reg_wr && (reg_addr == CTRL_ONE_ADDR);
    assign wr_two = reg_wr && (reg_addr == CTRL_TWO_ADDR);

    always_comb begin
        d = q;
        if (wr_one) begin
            d.test_sel = reg_wdata[TEST_SEL_BIT];
            d.halt     = reg_wdata[HALT_BIT];
            d.ovr      = reg_wdata[OVR_BIT];
        end
        if (wr_two) begin
            d.pulse_mode = reg_wdata[PULSE_BIT];
            d.alarm_irq_enable        = reg_wdata[AIE_BIT];
            d.countdown_irq_enable        = reg_wdata[TIE_BIT];
            d.af         = q.af & reg_wdata[AF_BIT];
            d.tf         = q.tf & reg_wdata[TF_BIT];
        end
        // Setting wins over a clearing write in the same cycle
        if (alarm_event) d.af = 1'b1;
        if (cd_end) d.tf = 1'b1;
        cd_cond = d.pulse_mode ? pulse_active : d.tf;
        // Built from next values so a clearing write drops it at once
        d.irq = (d.af & d.alarm_irq_enable) | (cd_cond & d.countdown_irq_enable);
        case (reg_addr)
            CTRL_ONE_ADDR: d.rdata = {q.test_sel, 1'b0, q.halt, 1'b0, q.ovr, 3'h0};
            CTRL_TWO_ADDR: d.rdata = {3'h0, q.pulse_mode, q.af, q.tf, q.alarm_irq_enable, q.countdown_irq_enable};
            default:       d.rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            q            <= '0;
            q.test_sel   <= CTRL_ONE_RST[TEST_SEL_BIT];
            q.halt       <= CTRL_ONE_RST[HALT_BIT];
            q.ovr        <= CTRL_ONE_RST[OVR_BIT];
            q.pulse_mode <= CTRL_TWO_RST[PULSE_BIT];
            q.af         <= CTRL_TWO_RST[AF_BIT];
            q.tf         <= CTRL_TWO_RST[TF_BIT];
            q.alarm_irq_enable        <= CTRL_TWO_RST[AIE_BIT];
            q.countdown_irq_enable        <= CTRL_TWO_RST[TIE_BIT];
            sq_q         <= 1'b0;
            src_q        <= 1'b0;
            sec_q        <= 1'b0;
        end else begin
            q     <= d;
            sq_q  <= sq_raw;
            src_q <= src_raw;
            sec_q <= sec_raw;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Outputs
    assign reg_rdata             = q.rdata;
    assign irq_n_out             = 1'b0;
    assign irq_n_oe              = q.irq;
    assign square_wave_out       = sq_q;
    assign countdown_tick        = src_q;
    assign second_tick           = sec_q;
    assign ext_clock_test_select = q.test_sel;
    assign divider_halted        = q.halt;
    assign reset_override_enable = q.ovr;

    //////////////////////////////////////////////////////////////////////////
    // Checks
    property p_af_set;
        @(posedge clk) disable iff (sys_rst) alarm_event |=> q.af;
    endproperty
    a_af_set: assert property (p_af_set) else $error("alarm flag not set");

    property p_tf_set;
        @(posedge clk) disable iff (sys_rst) cd_end |=> q.tf;
    endproperty
    a_tf_set: assert property (p_tf_set) else $error("countdown flag not set");

    property p_af_clear;
        @(posedge clk) disable iff (sys_rst)
            (wr_two && !reg_wdata[AF_BIT] && !alarm_event) |=> !q.af;
    endproperty
    a_af_clear: assert property (p_af_clear) else $error("alarm flag not cleared");

    property p_tf_clear;
        @(posedge clk) disable iff (sys_rst)
            (wr_two && !reg_wdata[TF_BIT] && !cd_end) |=> !q.tf;
    endproperty
    a_tf_clear: assert property (p_tf_clear) else $error("countdown flag not cleared");

    property p_and_keep;
        @(posedge clk) disable iff (sys_rst)
            (wr_two && reg_wdata[AF_BIT] && reg_wdata[TF_BIT]) |=>
                q.af == $past(q.af | alarm_event) && q.tf == $past(q.tf | cd_end);
    endproperty
    a_and_keep: assert property (p_and_keep) else $error("write disturbed a flag");

    property p_hold;
        @(posedge clk) disable iff (sys_rst)
            (!wr_two && q.af && q.tf) |=> q.af && q.tf;
    endproperty
    a_hold: assert property (p_hold) else $error("flag self-cleared");

    property p_level;
        @(posedge clk) disable iff (sys_rst) (!q.pulse_mode && q.countdown_irq_enable && q.tf) |-> irq_n_oe;
    endproperty
    a_level: assert property (p_level) else $error("level interrupt missing");

    property p_alarm_irq;
        @(posedge clk) disable iff (sys_rst) (q.af && q.alarm_irq_enable) |-> irq_n_oe && !irq_n_out;
    endproperty
    a_alarm_irq: assert property (p_alarm_irq) else $error("alarm interrupt missing");

    property p_quiet;
        @(posedge clk) disable iff (sys_rst) !(q.alarm_irq_enable || q.countdown_irq_enable) |-> !irq_n_oe;
    endproperty
    a_quiet: assert property (p_quiet) else $error("interrupt while disabled");

    sequence s_pulse_start;
        cd_end && q.pulse_mode && q.countdown_irq_enable && !q.alarm_irq_enable && !reg_wr;
    endsequence
    sequence s_pulse_seen;
        !reg_wr ##1 irq_n_oe;
    endsequence
    property p_pulse;
        @(posedge clk) disable iff (sys_rst) s_pulse_start |=> s_pulse_seen;
    endproperty
    a_pulse: assert property (p_pulse) else $error("pulse interrupt missing");

    property p_clear_drop;
        @(posedge clk) disable iff (sys_rst)
            (wr_two && reg_wdata[1:0] == 2'h0) |=> !irq_n_oe;
    endproperty
    a_clear_drop: assert property (p_clear_drop) else $error("interrupt did not drop");

    property p_read_two;
        @(posedge clk) disable iff (sys_rst)
            (reg_addr == CTRL_TWO_ADDR) |=>
                reg_rdata == $past({3'h0, q.pulse_mode, q.af, q.tf, q.alarm_irq_enable, q.countdown_irq_enable});
    endproperty
    a_read_two: assert property (p_read_two) else $error("bad readback");

    property p_reset_val;
        @(posedge clk) sys_rst |=> reset_override_enable && !divider_halted;
    endproperty
    a_reset_val: assert property (p_reset_val) else $error("bad reset value");
endmodule // rtc_control_status_irq

// [hw/rtc_ctl_pkg.sv]
package rtc_ctl_pkg;
    // Register map
    localparam logic [3:0] CTRL_ONE_ADDR  = 4'h0;
    localparam logic [3:0] CTRL_TWO_ADDR  = 4'h1;
    // First register fields
    localparam int TEST_SEL_BIT  = 7;
    localparam int HALT_BIT      = 5;
    localparam int OVR_BIT       = 3;
    // Second register fields
    localparam int PULSE_BIT     = 4;
    localparam int AF_BIT        = 3;
    localparam int TF_BIT        = 2;
    localparam int AIE_BIT       = 1;
    localparam int TIE_BIT       = 0;
    localparam logic [7:0] CTRL_ONE_RST = 8'h08;
    localparam logic [7:0] CTRL_TWO_RST = 8'h00;
    // Clocks
    localparam int unsigned CLK_HZ = 40000000;
    localparam int unsigned OSC_HZ = 32768;
    localparam int NCO_W = 26;
    localparam logic [NCO_W:0] NCO_MOD  = (NCO_W+1)'(CLK_HZ);
    localparam logic [NCO_W:0] NCO_STEP = (NCO_W+1)'(2 * OSC_HZ);
    localparam int DIV_W = 15;
    localparam logic [5:0] MIN_LAST = 6'h3b;
    // Countdown source select codes
    localparam logic [1:0] SRC_4096 = 2'h0;
    localparam logic [1:0] SRC_64   = 2'h1;
    localparam logic [1:0] SRC_1    = 2'h2;
    localparam logic [1:0] SRC_1_60 = 2'h3;
    // Pulse widths as fractions of a second, counted in oscillator periods
    localparam int unsigned PW_4096_ONE_DEN = 8192;
    localparam int unsigned PW_4096_DEN     = 4096;
    localparam int unsigned PW_64_ONE_DEN   = 128;
    localparam int unsigned PW_SLOW_DEN     = 64;
    localparam int PW_W = 10;
    localparam logic [PW_W-1:0] PW_4096_ONE = PW_W'(OSC_HZ / PW_4096_ONE_DEN);
    localparam logic [PW_W-1:0] PW_4096     = PW_W'(OSC_HZ / PW_4096_DEN);
    localparam logic [PW_W-1:0] PW_64_ONE   = PW_W'(OSC_HZ / PW_64_ONE_DEN);
    localparam logic [PW_W-1:0] PW_SLOW     = PW_W'(OSC_HZ / PW_SLOW_DEN);

    typedef struct packed {
        logic       test_sel;
        logic       halt;
        logic       ovr;
        logic       pulse_mode;
        logic       af;
        logic       tf;
        logic       alarm_irq_enable;
        logic       countdown_irq_enable;
        logic       irq;
        logic [7:0] rdata;
    } ctl_state_t;
endpackage

// [hw/rtc_prescaler.sv]
`timescale 1ns/1ps
module rtc_prescaler (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       halt,
    input  wire logic       test_mode,
    input  wire logic       external_test_clock,
    input  wire logic [1:0] src_sel,
    output logic            square_out,
    output logic            osc_tick,
    output logic            src_tick,
    output logic            sec_tick
);
    import rtc_ctl_pkg::*;

    typedef struct packed {
        logic [NCO_W-1:0] acc;
        logic             sq;
        logic             ext_prev;
        logic [DIV_W-1:0] div;
        logic [5:0]       mins;
        logic             osc_tick;
        logic             src_tick;
        logic             sec_tick;
    } pre_state_t;

    pre_state_t q, d;
    logic [NCO_W:0] sum;
    logic           tick2, adv, f4096, f64, f1, f160;

    always_comb begin
        d = q;
        sum = {1'b0, q.acc} + NCO_STEP;
        tick2 = (sum >= NCO_MOD);
        if (tick2) begin
            d.acc = NCO_W'(sum - NCO_MOD);
            d.sq  = ~q.sq;
        end else begin
            d.acc = sum[NCO_W-1:0];
        end
        // Test mode clocks the chain from the external pin
        adv = test_mode ? (external_test_clock & ~q.ext_prev) : (tick2 & ~q.sq);
        d.ext_prev = external_test_clock;
        f4096 = adv && (q.div[2:0] == 3'h7);
        f64   = adv && (q.div[8:0] == 9'h1ff);
        f1    = adv && (&q.div);
        f160  = f1 && (q.mins == MIN_LAST);
        d.osc_tick = adv;
        d.sec_tick = 1'b0;
        d.src_tick = 1'b0;
        if (halt) begin
            d.div  = '0;
            d.mins = '0;
        end else begin
            if (adv) d.div = q.div + 1'b1;
            if (f1) d.mins = f160 ? 6'h00 : q.mins + 6'h01;
            d.sec_tick = f1;
            case (src_sel)
                SRC_4096: d.src_tick = f4096;
                SRC_64:   d.src_tick = f64;
                SRC_1:    d.src_tick = f1;
                default:  d.src_tick = f160;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) q <= '0;
        else q <= d;
    end

    assign square_out = q.sq;
    assign osc_tick   = q.osc_tick;
    assign src_tick   = q.src_tick;
    assign sec_tick   = q.sec_tick;

    property p_halt_clears;
        @(posedge clk) disable iff (sys_rst) halt |=> q.div == '0 && !src_tick;
    endproperty
    a_halt_clears: assert property (p_halt_clears) else $error("divider not cleared");

    property p_square_runs;
        @(posedge clk) disable iff (sys_rst) (halt && tick2) |=> square_out != $past(square_out);
    endproperty
    a_square_runs: assert property (p_square_runs) else $error("square wave stalled");
endmodule // rtc_prescaler

// [verif/host_model.sv]
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Host side of the register port
module host_model (
    input  wire logic       clk,
    input  wire logic [7:0] reg_rdata,
    output logic      [3:0] reg_addr,
    output logic            reg_wr,
    output logic      [7:0] reg_wdata
);
    import rtc_ctl_pkg::*;

    initial begin
        reg_addr = 4'h0;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
    end

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] m;
        m = (a == CTRL_ONE_ADDR) ? 8'ha8 : (a == CTRL_TWO_ADDR) ? 8'h1f : 8'hff;
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_wdata = d & m;
        reg_wr = 1'b1;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        // Data not valid outside the strobe
        reg_wdata = ~reg_wdata;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        #1;
        reg_addr = a;
        @(posedge clk);
        #1;
        d = reg_rdata;
    endtask
endmodule // host_model

// [verif/tb.sv]
`timescale 1ns/1ps
module tb;
    import rtc_ctl_pkg::*;
    logic       clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic [3:0] reg_addr;
    logic       reg_wr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic       alarm_event = 1'b0;
    logic       countdown_zero = 1'b0;
    logic [1:0] countdown_src = SRC_4096;
    logic [7:0] countdown_load = 8'h02;
    logic       external_test_clock = 1'b0;
    logic       irq_n_out, irq_n_oe, square_wave_out, countdown_tick, second_tick;
    logic       ext_clock_test_select, divider_halted, reset_override_enable;
    int         num_errors = 0;
    int         n_checks = 0;
    int         cyc = 0;
    logic [7:0] v;

    always #12.5 clk = ~clk;

    rtc_control_status_irq rtc_control_status_irq_inst (
        .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .alarm_event(alarm_event),
        .countdown_zero(countdown_zero), .countdown_src(countdown_src),
        .countdown_load(countdown_load), .external_test_clock(external_test_clock),
        .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe), .square_wave_out(square_wave_out),
        .countdown_tick(countdown_tick), .second_tick(second_tick),
        .ext_clock_test_select(ext_clock_test_select), .divider_halted(divider_halted),
        .reset_override_enable(reset_override_enable)
    );
    host_model host_model_inst (
        .clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata)
    );

    //////////////////////////////////////////////////////////////////////////////
    // Helpers
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic fire(input bit alarm);
        @(posedge clk);
        #1;
        if (alarm) alarm_event = 1'b1;
        else countdown_zero = 1'b1;
        @(posedge clk);
        #1;
        alarm_event = 1'b0;
        countdown_zero = 1'b0;
    endtask

    // Counts ticks and square wave edges over a window
    task automatic watch(input int n, output int ticks, output int sq);
        logic last;
        ticks = 0;
        sq = 0;
        last = square_wave_out;
        repeat (n) begin
            @(posedge clk);
            #1;
            ticks += (countdown_tick === 1'b1) + (second_tick === 1'b1);
            sq += (square_wave_out !== last);
            last = square_wave_out;
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            num_errors++;
            report_and_stop;
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset;
        host_model_inst.rd(CTRL_ONE_ADDR, v);
        chk("reg0", 8'h08, v);
        host_model_inst.rd(CTRL_TWO_ADDR, v);
        chk("reg1", 8'h00, v);
        chk("irq_oe", 0, irq_n_oe);
        chk("irq_out", 0, irq_n_out);
        $display("test reset done");
    endtask

    task automatic t_ctrl_one;
        int tk, sq;
        host_model_inst.wr(CTRL_ONE_ADDR, 8'h20);
        chk("halt", 1, divider_halted);
        chk("ovr", 0, reset_override_enable);
        watch(12000, tk, sq);
        chk("halted_ticks", 0, tk);
        chk("square_runs", 1, sq >= 18);
        host_model_inst.wr(CTRL_ONE_ADDR, 8'h00);
        watch(12000, tk, sq);
        chk("running_ticks", 1, tk >= 1);
        // Halt clears the chain, then eight external edges give one 4096 Hz tick
        host_model_inst.wr(CTRL_ONE_ADDR, 8'h20);
        host_model_inst.wr(CTRL_ONE_ADDR, 8'h80);
        chk("test_sel", 1, ext_clock_test_select);
        repeat (8) begin
            @(posedge clk);
            #1;
            external_test_clock = 1'b1;
            @(posedge clk);
            #1;
            external_test_clock = 1'b0;
        end
        watch(6, tk, sq);
        chk("ext_clock_ticks", 1, tk);
        host_model_inst.rd(CTRL_ONE_ADDR, v);
        chk("reg0_test", 8'h80, v);
        host_model_inst.wr(CTRL_ONE_ADDR, 8'h00);
        chk("test_sel_off", 0, ext_clock_test_select);
        host_model_inst.wr(4'h2, 8'hff);
        host_model_inst.rd(CTRL_ONE_ADDR, v);
        chk("reg0_unmapped", 8'h00, v);
        host_model_inst.rd(4'h2, v);
        chk("addr2", 8'h00, v);
        $display("test control one done");
    endtask

    task automatic t_flags;
        host_model_inst.wr(CTRL_TWO_ADDR, 8'h03);
        fire(1'b1);
        chk("irq_alarm", 1, irq_n_oe);
        fire(1'b0);
        repeat (200) @(posedge clk);
        host_model_inst.rd(CTRL_TWO_ADDR, v);
        chk("both_flags", 8'h0f, v);
        host_model_inst.wr(CTRL_TWO_ADDR, 8'h0f);
        host_model_inst.rd(CTRL_TWO_ADDR, v);
        chk("and_keep", 8'h0f, v);
        host_model_inst.wr(CTRL_TWO_ADDR, 8'h0b);
        host_model_inst.rd(CTRL_TWO_ADDR, v);
        chk("and_write", 8'h0b, v);
        chk("irq_alarm_only", 1, irq_n_oe);
        host_model_inst.wr(CTRL_TWO_ADDR, 8'h03);
        chk("irq_drop", 0, irq_n_oe);
        fire(1'b0);
        chk("irq_level", 1, irq_n_oe);
        repeat (500) @(posedge clk);
        chk("irq_level_hold", 1, irq_n_oe);
        host_model_inst.wr(CTRL_TWO_ADDR, 8'h06);
        chk("irq_tie_off", 0, irq_n_oe);
        host_model_inst.wr(CTRL_TWO_ADDR, 8'h00);
        $display("test flags done");
    endtask

    // Pulse width at the 4096 Hz source, in oscillator periods
    task automatic t_pulse(input logic [7:0] n, input int periods);
        int w, ex;
        w = 0;
        countdown_load = n;
        host_model_inst.wr(CTRL_TWO_ADDR, 8'h11);
        fire(1'b0);
        repeat (2) if (irq_n_oe !== 1'b1) @(posedge clk);
        #1;
        chk("pulse_start", 1, irq_n_oe);
        while (irq_n_oe === 1'b1 && w < 20000) begin
            @(posedge clk);
            #1;
            w++;
        end
        ex = periods * CLK_HZ / OSC_HZ;
        chk("pulse_width", 1, (w > ex - 1300) && (w < ex + 1300));
        host_model_inst.rd(CTRL_TWO_ADDR, v);
        chk("tf_after_pulse", 8'h15, v);
        host_model_inst.wr(CTRL_TWO_ADDR, 8'h11);
        $display("test pulse done");
    endtask

    task automatic t_pulse_alarm;
        host_model_inst.wr(CTRL_TWO_ADDR, 8'h13);
        fire(1'b1);
        fire(1'b0);
        repeat (12000) @(posedge clk);
        chk("alarm_hold", 1, irq_n_oe);
        host_model_inst.wr(CTRL_TWO_ADDR, 8'h13);
        chk("alarm_clear", 0, irq_n_oe);
        $display("test pulse alarm done");
    endtask

    initial begin
        repeat (2) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        t_reset();
        t_ctrl_one();
        t_flags();
        t_pulse(8'h01, 4);
        t_pulse(8'h02, 8);
        t_pulse_alarm();
        report_and_stop();
    end
endmodule // tb
